// File: rtl/debug_cmd_core.sv
// Summary of operation
// [RL1] One watchpoint on one register address, read/write.
// [RL2] Optional data compare qualifies the watchpoint.
// [RL3] Watchpoint hit enters debug mode, sets flag.
// [RL4] 16-bit runtime counter counts outside debug mode.
// [RL5] Counter starts at zero and saturates.
// [RL6] Counter may be overwritten by memory commands.
// [RL7] Command byte codes 00H and 02H to 07H decoded.
// [RL8] Outside debug mode only 00H,02H,04H,05H work.
// [RL9] Read protect disables program counter access.
// [RL10] Protected register writes only flash mass erase; the code also accepts any data at flash addresses other than FLASH_CTL.
// [RL11] Revision reply: major byte then minor byte.
// [RL12] Status read replies one status byte.
// [RL13] Runtime read replies two bytes, high first.
// [RL14] Control write stores byte; protect keeps halt.
// [RL15] Control read replies control register byte.
// [RL16] Program counter write, high first, gated.
// [RL17] Program counter read, all ones when gated.
// [RL18] Characters: start, eight LSB-first, 1.5 stop.
// [RL19] Host sends 80H first for baud detection.
// [RL20] Serial error aborts command, sends break.
// [RL21] Reserved or unavailable commands silently ignored.
// [RL22] Counter cleared on each debug mode exit; a run_load in the first cycle after exit loads run_load_data instead.
`timescale 1ns/1ps
module debug_cmd_core
  import debug_core_pkg::*;
#(
  parameter logic [15:0] REVISION   = REVISION_DEF,
  parameter logic [11:0] FLASH_LO   = FLASH_LO_DEF,
  parameter logic [11:0] FLASH_HI   = FLASH_HI_DEF,
  parameter logic [11:0] FLASH_CTL  = FLASH_CTL_DEF,
  parameter logic [7:0]  MASS_ERASE = MASS_ERASE_DEF
) (
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic [7:0]  rx_data_in,
  input  wire logic        rx_valid_in,
  input  wire logic        tx_ready_in,
  input  wire logic        serial_error_in,
  input  wire logic        read_protect_option_in,
  input  wire logic        brk_in,
  input  wire logic [15:0] pc_in,
  input  wire logic [11:0] rf_addr_in,
  input  wire logic [7:0]  rf_data_in,
  input  wire logic        rf_rd_in,
  input  wire logic        rf_wr_in,
  input  wire logic [11:0] wpt_addr_in,
  input  wire logic [7:0]  wpt_data_in,
  input  wire logic        wpt_on_read_in,
  input  wire logic        wpt_on_write_in,
  input  wire logic        wpt_data_cmp_in,
  input  wire logic        reg_wr_req_in,
  input  wire logic [11:0] reg_wr_addr_in,
  input  wire logic [7:0]  reg_wr_data_in,
  input  wire logic        run_load_in,
  input  wire logic [15:0] run_load_data_in,
  output logic [7:0]       tx_data_out,
  output logic             tx_valid_out,
  output logic             send_break_out,
  output logic             baud_reset_out,
  output logic             debug_halt_flag_out,
  output logic [7:0]       debugger_control_reg_out,
  output logic             pc_wr_out,
  output logic [15:0]      pc_wr_data_out,
  output logic             reg_wr_accept_out
);

  // ------------------------------------------------------------
  // Shared links to the watchpoint and the runtime counter
  // ------------------------------------------------------------
  debug_core_if link ();

  watchpoint_unit u_watch (
    .core_clk_in     (core_clk_in),
    .rst_in          (rst_in),
    .rf_addr_in      (rf_addr_in),
    .rf_data_in      (rf_data_in),
    .rf_rd_in        (rf_rd_in),
    .rf_wr_in        (rf_wr_in),
    .wpt_addr_in     (wpt_addr_in),
    .wpt_data_in     (wpt_data_in),
    .wpt_on_read_in  (wpt_on_read_in),
    .wpt_on_write_in (wpt_on_write_in),
    .wpt_data_cmp_in (wpt_data_cmp_in),
    .link            (link.watch)
  );

  runtime_counter u_run (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .link        (link.counter)
  );

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    core_state_t state;
    logic [7:0]  cmd;
    logic [7:0]  ctl;
    logic [7:0]  arg_hi;
    logic [7:0]  tx_data;
    logic        tx_valid;
    logic [7:0]  second;
    logic        send_break;
    logic        baud_reset;
    logic        pc_wr;
    logic [15:0] pc_wr_data;
    logic        reg_wr_accept;
  } core_reg_t;

  core_reg_t st;
  core_reg_t next_st;

  logic       in_debug;
  logic       protect;
  logic       allowed;
  logic [7:0] status;

  // ------------------------------------------------------------
  // Mode, protection and status byte
  // ------------------------------------------------------------
  assign in_debug = st.ctl[CTL_HALT_BIT];
  assign protect  = read_protect_option_in;

  always_comb begin
    status                = ZERO8;
    status[STAT_HALT_BIT] = in_debug;
    status[STAT_RP_BIT]   = protect;
  end

  // ------------------------------------------------------------
  // Command availability
  // ------------------------------------------------------------
  // Availability of a command byte in the present mode.
  // Program counter commands are always taken so that their argument bytes are never decoded as commands.
  always_comb begin
    unique case (rx_data_in)                                   // see [RL7]
      CMD_REVISION, CMD_STATUS, CMD_CTL_WR, CMD_CTL_RD: begin
        allowed = 1'b1;                                        // see [RL8]
      end
      CMD_RUNTIME: begin
        allowed = in_debug;                                    // see [RL8]
      end
      CMD_PC_WR, CMD_PC_RD: begin
        allowed = 1'b1;                                        // see [RL16] [RL17]
      end
      default: begin
        allowed = 1'b0;                                        // see [RL21]
      end
    endcase
  end

  // ------------------------------------------------------------
  // Command sequencer
  // ------------------------------------------------------------
  always_comb begin
    next_st            = st;
    next_st.send_break = 1'b0;
    next_st.baud_reset = 1'b0;
    next_st.pc_wr      = 1'b0;

    // Protected register writes may only reach the flash controller.
    next_st.reg_wr_accept = reg_wr_req_in && in_debug
                            && (!protect || ((reg_wr_addr_in >= FLASH_LO) && (reg_wr_addr_in <= FLASH_HI)
                            && ((reg_wr_addr_in != FLASH_CTL) || (reg_wr_data_in == MASS_ERASE)))); // see [RL10]

    if (link.watch_hit || (brk_in && st.ctl[CTL_BRKEN_BIT])) begin
      next_st.ctl[CTL_HALT_BIT] = 1'b1;                        // see [RL3]
    end

    if (serial_error_in) begin
      next_st.state      = ST_IDLE;                            // see [RL20]
      next_st.tx_valid   = 1'b0;
      next_st.send_break = 1'b1;
      // An error aborts any command in flight, including a reply being sent.
      // The host must send the baud character again after the break.
      next_st.baud_reset = 1'b1;                               // see [RL19]
    end else begin
      unique case (st.state)
        ST_IDLE: begin
          // Bytes arrive here already deframed by the receiver.
          if (rx_valid_in && allowed) begin                    // see [RL18]
            next_st.cmd = rx_data_in;
            unique case (rx_data_in)
              CMD_REVISION: begin
                next_st.tx_data  = REVISION[15:8];             // see [RL11]
                next_st.second   = REVISION[7:0];
                next_st.tx_valid = 1'b1;
                next_st.state    = ST_SEND2;
              end
              CMD_STATUS: begin
                next_st.tx_data  = status;                     // see [RL12]
                next_st.tx_valid = 1'b1;
                next_st.state    = ST_SEND1;
              end
              CMD_RUNTIME: begin
                next_st.tx_data  = link.run_count[15:8];       // see [RL13]
                next_st.second   = link.run_count[7:0];
                next_st.tx_valid = 1'b1;
                next_st.state    = ST_SEND2;
              end
              CMD_CTL_RD: begin
                next_st.tx_data  = st.ctl;                     // see [RL15]
                next_st.tx_valid = 1'b1;
                next_st.state    = ST_SEND1;
              end
              CMD_PC_RD: begin
                // A gated read still answers two bytes so that the host stays in step.
                if (in_debug && !protect) begin
                  next_st.tx_data = pc_in[15:8];               // see [RL17]
                  next_st.second  = pc_in[7:0];
                end else begin
                  next_st.tx_data = ALL_ONES16[15:8];          // see [RL9] [RL17]
                  next_st.second  = ALL_ONES16[7:0];
                end
                next_st.tx_valid = 1'b1;
                next_st.state    = ST_SEND2;
              end
              default: begin
                next_st.state = ST_ARG1;
              end
            endcase
          end
        end
        ST_ARG1: begin
          if (rx_valid_in) begin
            if (st.cmd == CMD_CTL_WR) begin
              next_st.ctl = rx_data_in & CTL_WR_MASK;          // see [RL14]
              if (protect && st.ctl[CTL_HALT_BIT]) begin
                next_st.ctl[CTL_HALT_BIT] = 1'b1;              // see [RL14]
              end
              if (link.watch_hit || (brk_in && st.ctl[CTL_BRKEN_BIT])) begin
                next_st.ctl[CTL_HALT_BIT] = 1'b1;
              end
              next_st.state = ST_IDLE;
            end else begin
              // A gated program counter write still takes both argument bytes.
              next_st.arg_hi = rx_data_in;                     // see [RL16]
              next_st.state  = ST_ARG2;
            end
          end
        end
        ST_ARG2: begin
          if (rx_valid_in) begin
            next_st.pc_wr      = in_debug && !protect;         // see [RL16]
            next_st.pc_wr_data = {st.arg_hi, rx_data_in};
            next_st.state      = ST_IDLE;
          end
        end
        ST_SEND2: begin
          if (tx_ready_in) begin
            next_st.tx_data = st.second;
            next_st.state   = ST_SEND1;
          end
        end
        ST_SEND1: begin
          if (tx_ready_in) begin
            next_st.tx_valid = 1'b0;
            next_st.state    = ST_IDLE;
          end
        end
        default: begin
          next_st.state = ST_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  // Reset leaves the block idle, outside debug mode and silent.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st       <= '0;
      st.state <= ST_IDLE;
      st.ctl   <= CTL_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign link.debug_mode    = st.ctl[CTL_HALT_BIT];
  assign link.run_load      = run_load_in;
  assign link.run_load_data = run_load_data_in;

  // Every output is a state flip-flop, with no logic after it.
  assign tx_data_out              = st.tx_data;
  assign tx_valid_out             = st.tx_valid;
  assign send_break_out           = st.send_break;
  assign baud_reset_out           = st.baud_reset;
  assign debug_halt_flag_out      = st.ctl[CTL_HALT_BIT];
  assign debugger_control_reg_out = st.ctl;
  assign pc_wr_out                = st.pc_wr;
  assign pc_wr_data_out           = st.pc_wr_data;
  assign reg_wr_accept_out        = st.reg_wr_accept;

endmodule

// File: rtl/debug_core_pkg.sv
package debug_core_pkg;

  // ------------------------------------------------------------
  // Command codes
  // ------------------------------------------------------------
  localparam logic [7:0] CMD_REVISION = 8'h00;
  localparam logic [7:0] CMD_STATUS   = 8'h02;
  localparam logic [7:0] CMD_RUNTIME  = 8'h03;
  localparam logic [7:0] CMD_CTL_WR   = 8'h04;
  localparam logic [7:0] CMD_CTL_RD   = 8'h05;
  localparam logic [7:0] CMD_PC_WR    = 8'h06;
  localparam logic [7:0] CMD_PC_RD    = 8'h07;

  // ------------------------------------------------------------
  // Control register layout
  // ------------------------------------------------------------
  localparam int         CTL_HALT_BIT  = 7;
  localparam int         CTL_BRKEN_BIT = 6;
  localparam int         CTL_RST_BIT   = 0;
  localparam logic [7:0] CTL_WR_MASK   = 8'he1;
  localparam logic [7:0] CTL_RESET     = 8'h00;

  // ------------------------------------------------------------
  // Status register layout
  // ------------------------------------------------------------
  localparam int STAT_HALT_BIT = 7;
  localparam int STAT_RP_BIT   = 6;

  // ------------------------------------------------------------
  // Constant values
  // ------------------------------------------------------------
  localparam logic [15:0] ALL_ONES16   = 16'hffff;
  localparam logic [15:0] ZERO16       = 16'h0000;
  localparam logic [7:0]  ZERO8        = 8'h00;
  localparam logic [15:0] REVISION_DEF = 16'h0100;
  localparam logic [11:0] FLASH_LO_DEF = 12'hff8;
  localparam logic [11:0] FLASH_HI_DEF = 12'hfff;
  localparam logic [11:0] FLASH_CTL_DEF = 12'hff8;
  localparam logic [7:0]  MASS_ERASE_DEF = 8'h63;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ARG1  = 3'b001,
    ST_ARG2  = 3'b010,
    ST_SEND1 = 3'b011,
    ST_SEND2 = 3'b100
  } core_state_t;

endpackage

// File: rtl/debug_core_if.sv
`timescale 1ns/1ps
interface debug_core_if;
  logic        debug_mode;
  logic        watch_hit;
  logic [15:0] run_count;
  logic        run_load;
  logic [15:0] run_load_data;

  modport core    (output debug_mode, output run_load, output run_load_data,
                   input watch_hit, input run_count);
  modport watch   (input debug_mode, output watch_hit);
  modport counter (input debug_mode, input run_load, input run_load_data, output run_count);
endinterface

// File: rtl/watchpoint_unit.sv
`timescale 1ns/1ps
module watchpoint_unit
  import debug_core_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic [11:0] rf_addr_in,
  input  wire logic [7:0]  rf_data_in,
  input  wire logic        rf_rd_in,
  input  wire logic        rf_wr_in,
  input  wire logic [11:0] wpt_addr_in,
  input  wire logic [7:0]  wpt_data_in,
  input  wire logic        wpt_on_read_in,
  input  wire logic        wpt_on_write_in,
  input  wire logic        wpt_data_cmp_in,
  debug_core_if.watch      link
);

  typedef struct packed {
    logic hit;
  } watch_state_t;

  watch_state_t st;
  watch_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.hit = !link.debug_mode && (rf_addr_in == wpt_addr_in)
                  && ((rf_rd_in && wpt_on_read_in) || (rf_wr_in && wpt_on_write_in)) // see [RL1]
                  && (!wpt_data_cmp_in || (rf_data_in == wpt_data_in));                 // see [RL2]
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign link.watch_hit = st.hit;

endmodule

// File: rtl/runtime_counter.sv
`timescale 1ns/1ps
module runtime_counter
  import debug_core_pkg::*;
(
  input  wire logic   core_clk_in,
  input  wire logic   rst_in,
  debug_core_if.counter link
);

  typedef struct packed {
    logic [15:0] count;
    logic        was_debug;
  } run_state_t;

  run_state_t st;
  run_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.was_debug = link.debug_mode;
    if (link.run_load) begin
      next_st.count = link.run_load_data;                      // see [RL6]
    end else if (st.was_debug && !link.debug_mode) begin
      next_st.count = ZERO16;                                  // see [RL22]
    end else if (!link.debug_mode && st.count != ALL_ONES16) begin
      next_st.count = st.count + 16'h0001;                     // see [RL4]
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st <= '0;                                                // see [RL5]
    end else begin
      st <= next_st;
    end
  end

  assign link.run_count = st.count;

endmodule

// File: tb/host_byte_model.sv
`timescale 1ns/1ps
module host_byte_model (
  input  wire logic       core_clk_in,
  input  wire logic [1:0] mode_in,
  output logic            tx_ready_out
);
  // Mode 0 takes every byte, mode 1 stalls at random, mode 2 never takes one.
  initial tx_ready_out = 1'b0;
  always @(negedge core_clk_in) begin
    tx_ready_out <= (mode_in == 2'd0) | ((mode_in == 2'd1) & 1'($urandom_range(1)));
  end
endmodule

// File: tb/debug_cmd_core_assertions.sv
`timescale 1ns/1ps
module debug_cmd_core_assertions
  import debug_core_pkg::*;
#(
  parameter logic [11:0] FLASH_LO   = FLASH_LO_DEF,
  parameter logic [11:0] FLASH_HI   = FLASH_HI_DEF,
  parameter logic [11:0] FLASH_CTL  = FLASH_CTL_DEF,
  parameter logic [7:0]  MASS_ERASE = MASS_ERASE_DEF
) (
  input wire logic        core_clk_in, rst_in, rx_valid_in, tx_ready_in, serial_error_in,
  input wire logic        read_protect_option_in, rf_rd_in, rf_wr_in, reg_wr_req_in,
  input wire logic        wpt_on_read_in, wpt_on_write_in, wpt_data_cmp_in,
  input wire logic [11:0] rf_addr_in, wpt_addr_in, reg_wr_addr_in,
  input wire logic [7:0]  rf_data_in, wpt_data_in, reg_wr_data_in, tx_data_out, debugger_control_reg_out,
  input wire logic        tx_valid_out, send_break_out, baud_reset_out, debug_halt_flag_out,
  input wire logic        pc_wr_out, reg_wr_accept_out, brk_in
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_watch_access;
    !debug_halt_flag_out && rf_addr_in == wpt_addr_in &&
    ((rf_rd_in && wpt_on_read_in) || (rf_wr_in && wpt_on_write_in)) &&
    (!wpt_data_cmp_in || rf_data_in == wpt_data_in);
  endsequence
  a_reply_cause: assert property ($rose(tx_valid_out) |-> $past(rx_valid_in))
    else $error("reply byte without a command byte");
  a_tx_hold: assert property (tx_valid_out && !tx_ready_in && !serial_error_in |=>
    tx_valid_out && $stable(tx_data_out)) else $error("reply byte dropped or changed");
  a_error_break: assert property (serial_error_in |=> send_break_out && baud_reset_out && !tx_valid_out)
    else $error("serial error not answered by break");
  a_break_cause: assert property ($rose(send_break_out) |-> $past(serial_error_in))
    else $error("break without serial error");
  a_watch_halt: assert property (s_watch_access |-> ##2 debug_halt_flag_out)
    else $error("watch match did not halt");
  a_halt_cause: assert property ($rose(debug_halt_flag_out) |->
    $past(rx_valid_in) || $past(brk_in) || $past(rf_rd_in || rf_wr_in, 2))
    else $error("halt entered without a cause");
  a_protect_halt: assert property (read_protect_option_in && debug_halt_flag_out |=> debug_halt_flag_out)
    else $error("halt cleared under protection");
  a_pc_gate: assert property (pc_wr_out |-> debug_halt_flag_out && !read_protect_option_in)
    else $error("program counter load outside debug or protected");
  a_ctl_reserved: assert property ((debugger_control_reg_out & ~CTL_WR_MASK) == ZERO8)
    else $error("reserved control bits set");
  a_regwr_protect: assert property (reg_wr_accept_out && read_protect_option_in |->
    $past(reg_wr_req_in) && $past(reg_wr_addr_in) >= FLASH_LO && $past(reg_wr_addr_in) <= FLASH_HI &&
    ($past(reg_wr_addr_in) != FLASH_CTL || $past(reg_wr_data_in) == MASS_ERASE))
    else $error("protected register write accepted");
endmodule
bind debug_cmd_core debug_cmd_core_assertions #(.FLASH_LO(FLASH_LO), .FLASH_HI(FLASH_HI),
  .FLASH_CTL(FLASH_CTL), .MASS_ERASE(MASS_ERASE)) i_chk (.*);

// File: tb/tb.sv
`timescale 1ns/1ps
module tb;
  import debug_core_pkg::*;
  localparam logic [15:0] REV = 16'h5a3c;
  localparam logic [7:0] IDLE_CODES [7] = '{8'h01, 8'h03, 8'h0f, 8'h13, 8'h14, 8'h1e, 8'h1f};
  logic        core_clk_in, rst_in, rx_valid_in, tx_ready_in, serial_error_in, read_protect_option_in;
  logic        brk_in, rf_rd_in, rf_wr_in, wpt_on_read_in, wpt_on_write_in, wpt_data_cmp_in;
  logic        reg_wr_req_in, run_load_in, tx_valid_out, send_break_out, baud_reset_out;
  logic        debug_halt_flag_out, pc_wr_out, reg_wr_accept_out;
  logic [7:0]  rx_data_in, rf_data_in, wpt_data_in, reg_wr_data_in, tx_data_out, debugger_control_reg_out;
  logic [11:0] rf_addr_in, wpt_addr_in, reg_wr_addr_in;
  logic [15:0] pc_in, run_load_data_in, pc_wr_data_out, pc_seen;
  logic [1:0]  host_mode;
  logic [7:0]  q [$];
  int          fail_count, n_tests, acc_cnt;

  debug_cmd_core #(.REVISION(REV)) i_debug_cmd_core (.core_clk_in, .rst_in, .rx_data_in, .rx_valid_in,
    .tx_ready_in, .serial_error_in, .read_protect_option_in, .brk_in, .pc_in, .rf_addr_in, .rf_data_in,
    .rf_rd_in, .rf_wr_in, .wpt_addr_in, .wpt_data_in, .wpt_on_read_in, .wpt_on_write_in, .wpt_data_cmp_in,
    .reg_wr_req_in, .reg_wr_addr_in, .reg_wr_data_in, .run_load_in, .run_load_data_in, .tx_data_out,
    .tx_valid_out, .send_break_out, .baud_reset_out, .debug_halt_flag_out, .debugger_control_reg_out,
    .pc_wr_out, .pc_wr_data_out, .reg_wr_accept_out);
  host_byte_model i_host_byte_model (.core_clk_in, .mode_in(host_mode), .tx_ready_out(tx_ready_in));

  always #5 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    if (tx_valid_out === 1'b1 && tx_ready_in === 1'b1) q.push_back(tx_data_out);
    if (pc_wr_out === 1'b1) pc_seen = pc_wr_data_out;
    if (reg_wr_accept_out === 1'b1) acc_cnt++;
  end

  function automatic logic [7:0] ctl_exp(input logic [7:0] w, input logic [7:0] old, input logic rp);
    return (w & CTL_WR_MASK) | (rp ? (old & 8'h80) : 8'h00);
  endfunction
  function automatic logic [15:0] stat_exp(input logic dbg, input logic rp);
    return {8'h00, dbg, rp, 6'h00};
  endfunction

  task automatic print_verdict();
    if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic send(input logic [23:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(negedge core_clk_in);
      rx_valid_in = 1'b1;
      rx_data_in = w[8*i+:8];
    end
    @(negedge core_clk_in);
    rx_valid_in = 1'b0;
  endtask
  // Sends a command of n bytes and expects m reply bytes, high byte first, and nothing more.
  task automatic cmd(input logic [23:0] w, input int n, input logic [15:0] exp, input int m);
    logic [15:0] got;
    got = 16'h0000;
    send(w, n);
    for (int t = 0; t < 200 && q.size() < m; t++) @(negedge core_clk_in);
    if (q.size() < m) begin
      fail_count++;
      print_verdict();
    end
    repeat (3) @(negedge core_clk_in);
    check(16'(q.size()), 16'(m));
    for (int i = 0; i < m; i++) got = {got[7:0], q.pop_front()};
    check(got, exp);
    q.delete();
  endtask
  task automatic rf_access(input logic [11:0] a, input logic [7:0] d, input logic wr, input logic e);
    @(negedge core_clk_in);
    {rf_addr_in, rf_data_in, rf_wr_in, rf_rd_in} = {a, d, wr, ~wr};
    @(negedge core_clk_in);
    {rf_wr_in, rf_rd_in} = 2'b00;
    repeat (3) @(negedge core_clk_in);
    check(16'(debug_halt_flag_out), 16'(e));
  endtask
  task automatic regw(input logic [11:0] a, input logic [7:0] d, input int e);
    acc_cnt = 0;
    @(negedge core_clk_in);
    {reg_wr_req_in, reg_wr_addr_in, reg_wr_data_in} = {1'b1, a, d};
    @(negedge core_clk_in);
    reg_wr_req_in = 1'b0;
    repeat (2) @(negedge core_clk_in);
    check(16'(acc_cnt), 16'(e));
  endtask

  initial begin
    logic [15:0] v;
    {core_clk_in, rx_valid_in, serial_error_in, read_protect_option_in, brk_in, rf_rd_in, rf_wr_in} = '0;
    {wpt_on_read_in, wpt_on_write_in, wpt_data_cmp_in, reg_wr_req_in, run_load_in, rx_data_in} = '0;
    {rf_data_in, wpt_data_in, reg_wr_data_in, rf_addr_in, wpt_addr_in, reg_wr_addr_in} = '0;
    {pc_in, run_load_data_in, pc_seen} = '0;
    rst_in = 1'b1;
    host_mode = 2'd1;
    void'($urandom(24));
    repeat (20) @(posedge core_clk_in);
    @(negedge core_clk_in);
    rst_in = 1'b0;
    cmd(24'h00, 1, REV, 2);
    cmd(24'h02, 1, stat_exp(1'b0, 1'b0), 1);
    foreach (IDLE_CODES[i]) cmd({16'h0, IDLE_CODES[i]}, 1, 16'h0, 0);
    cmd({16'h0, 8'($urandom_range(255, 34))}, 1, 16'h0, 0);
    cmd(24'h07, 1, ALL_ONES16, 2);
    cmd({8'h06, 16'($urandom)}, 3, 16'h0, 0);
    check(pc_seen, ZERO16);
    cmd(24'h045e, 2, 16'h0, 0);
    cmd(24'h05, 1, {8'h00, ctl_exp(8'h5e, 8'h00, 1'b0)}, 1);
    @(negedge core_clk_in);
    brk_in = 1'b1;
    @(negedge core_clk_in);
    brk_in = 1'b0;
    cmd(24'h02, 1, stat_exp(1'b1, 1'b0), 1);
    v = 16'($urandom);
    @(negedge core_clk_in);
    {run_load_in, run_load_data_in} = {1'b1, v};
    @(negedge core_clk_in);
    run_load_in = 1'b0;
    cmd(24'h03, 1, v, 2);
    pc_in = 16'($urandom);
    cmd(24'h07, 1, pc_in, 2);
    v = 16'($urandom);
    cmd({8'h06, v}, 3, 16'h0, 0);
    check(pc_seen, v);
    regw(12'h123, 8'h55, 1);
    cmd(24'h0440, 2, 16'h0, 0);
    repeat (65600) @(negedge core_clk_in);
    cmd(24'h04c0, 2, 16'h0, 0);
    cmd(24'h03, 1, 16'hffff, 2);
    cmd(24'h0440, 2, 16'h0, 0);
    cmd(24'h04c0, 2, 16'h0, 0);
    host_mode = 2'd0;
    send(24'h03, 1);
    repeat (12) @(negedge core_clk_in);
    check(16'(q.size()), 16'h2);
    v = {q[0], q[1]};
    check(16'(v < 16'h0040), 16'h1);
    q.delete();
    host_mode = 2'd1;
    cmd(24'h0400, 2, 16'h0, 0);
    {wpt_addr_in, wpt_data_in, wpt_on_write_in, wpt_data_cmp_in} = {12'($urandom), 8'($urandom), 2'b11};
    rf_access(wpt_addr_in, ~wpt_data_in, 1'b1, 1'b0);
    rf_access(wpt_addr_in + 12'h1, wpt_data_in, 1'b1, 1'b0);
    rf_access(wpt_addr_in, wpt_data_in, 1'b0, 1'b0);
    rf_access(wpt_addr_in, wpt_data_in, 1'b1, 1'b1);
    cmd(24'h05, 1, 16'h0080, 1);
    cmd(24'h0400, 2, 16'h0, 0);
    {wpt_on_read_in, wpt_on_write_in, wpt_data_cmp_in} = 3'b100;
    rf_access(wpt_addr_in, 8'($urandom), 1'b0, 1'b1);
    host_mode = 2'd2;
    send(24'h00, 1);
    @(negedge core_clk_in);
    serial_error_in = 1'b1;
    @(negedge core_clk_in);
    {serial_error_in, host_mode} = {1'b0, 2'd1};
    repeat (4) @(negedge core_clk_in);
    check(16'(q.size()), 16'h0);
    cmd(24'h00, 1, REV, 2);
    read_protect_option_in = 1'b1;
    repeat (2) @(negedge core_clk_in);
    cmd(24'h02, 1, stat_exp(1'b1, 1'b1), 1);
    cmd(24'h07, 1, ALL_ONES16, 2);
    v = pc_seen;
    cmd(24'h061234, 3, 16'h0, 0);
    check(pc_seen, v);
    cmd(24'h0400, 2, 16'h0, 0);
    cmd(24'h05, 1, {8'h00, ctl_exp(8'h00, 8'h80, 1'b1)}, 1);
    regw(12'hff8, 8'h63, 1);
    regw(12'hff8, 8'h00, 0);
    regw(12'h100, 8'h55, 0);
    regw(12'hff9, 8'haa, 1);
    print_verdict();
  end
endmodule
